// ==== core/adc_seq_pkg.sv ====
// Constants and types shared by the conversion mode sequencer
package adc_seq_pkg;

	// ****************************************
	// Field sizes and mode addresses
	// ****************************************
	localparam int RESULT_W = 8;
	localparam int INFO_W = 4;
	localparam int CFG_W = 12;
	localparam int MODE_BITS = 4;
	localparam int SINGLE_BITS = 8;
	localparam int AUTO_BITS = 16;
	localparam int OUT_BITS = 12;
	localparam logic [3:0] MODE_SINGLE = 4'hA;
	localparam logic [3:0] MODE_AUTO = 4'hE;

	// ****************************************
	// Multiplexer codes per channel pair
	// ****************************************
	localparam logic [1:0] MUX_EVEN = 2'h0;
	localparam logic [1:0] MUX_DIFF = 2'h1;
	localparam logic [1:0] MUX_ODD = 2'h2;
	localparam logic [1:0] MUX_INVALID = 2'h3;
	localparam int PAIR_CODE_W = 3;
	localparam int PAIR_EN_BIT = 2;
	localparam int MAX_PAIRS = 4;

	// ****************************************
	// Timing, in oscillator periods, microseconds and system clocks; FIFO depth
	// ****************************************
	localparam logic [4:0] START_OSC_EDGES = 5'h02;
	localparam logic [4:0] CONV_OSC_PERIODS = 5'h11;
	localparam int CLK_MHZ = 10;
	localparam int CONV_MAX_US = 74;
	localparam int CONV_MAX_CYC = CONV_MAX_US * CLK_MHZ;
	localparam int FIFO_DEPTH = 16;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE, ST_SHIFT_IN, ST_HOLD, ST_START, ST_CONV, ST_READY, ST_SHIFT_OUT, ST_HIZ
	} seq_state_e;

	typedef struct packed {
		logic [INFO_W-1:0] info;
		logic [RESULT_W-1:0] result;
	} out_word_s;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic sdi;
		logic osc;
	} link_pins_s;

endpackage

// ==== core/adc_conversion_mode_sequencer.sv ====
// Conversion mode sequencer with its result FIFO
`timescale 1ns/1ns

// ****************************************
// Result FIFO
// ****************************************
module word_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_st_s;

	fifo_st_s q, d;
	logic push, pop;

	assign in_ready = q.cnt != (AW+1)'(DEPTH);
	assign out_valid = q.cnt != '0;
	assign out_data = q.mem[q.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointers wrap by overflow, so DEPTH must be a power of two
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

module adc_conversion_mode_sequencer #(
	parameter bit WIDE_VARIANT = 1'b1,
	parameter int FIFO_DEPTH = adc_seq_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// Conversion timing
	input wire logic conversion_oscillator,
	output logic eoc,
	// Analog front end
	input wire logic [adc_seq_pkg::RESULT_W-1:0] sample_value,
	input wire logic sample_diff_neg,
	output logic [1:0] mux_pair,
	output logic [1:0] mux_code,
	output logic auto_mode
);
	localparam int NUM_PAIRS = WIDE_VARIANT ? adc_seq_pkg::MAX_PAIRS : 1;

	// Local copy so the state names resolve without an import
	typedef enum logic [2:0] {
		ST_IDLE, ST_SHIFT_IN, ST_HOLD, ST_START, ST_CONV, ST_READY, ST_SHIFT_OUT, ST_HIZ
	} seq_state_e;

	typedef struct packed {
		adc_seq_pkg::link_pins_s sync1;
		adc_seq_pkg::link_pins_s sync2;
		adc_seq_pkg::link_pins_s sync3;
		seq_state_e state;
		logic mode_auto;
		logic [15:0] in_sh;
		logic [4:0] bit_cnt;
		logic [4:0] osc_cnt;
		logic [adc_seq_pkg::INFO_W-1:0] info;
		logic [adc_seq_pkg::CFG_W-1:0] cfg;
		logic [1:0] pair;
		logic [1:0] code;
		logic [adc_seq_pkg::OUT_BITS-1:0] out_sh;
		logic sdo;
		logic sdo_oe;
		logic eoc;
	} seq_st_s;

	seq_st_s q, d;
	adc_seq_pkg::link_pins_s pins;
	adc_seq_pkg::out_word_s push_word, pop_word;
	logic cs_fall, cs_rise, sclk_rise, osc_rise, sdi;
	logic push, fifo_in_ready, fifo_out_valid, pop;
	logic [3:0] mode_now;
	logic [2:0] first_pair, after_pair;

	assign pins = '{cs_n: cs_n, sclk: sclk, sdi: serial_in, osc: conversion_oscillator};
	assign cs_fall = q.sync3.cs_n & ~q.sync2.cs_n;
	assign cs_rise = ~q.sync3.cs_n & q.sync2.cs_n;
	assign sclk_rise = ~q.sync3.sclk & q.sync2.sclk;
	assign osc_rise = ~q.sync3.osc & q.sync2.osc;
	assign sdi = q.sync2.sdi;
	assign mode_now = {q.in_sh[2:0], sdi};

	// Enabled pair with a valid multiplexer code
	function automatic logic pair_ok(input logic [11:0] cfg, input logic [1:0] p);
		logic [2:0] c;
		c = cfg[int'(p)*adc_seq_pkg::PAIR_CODE_W +: adc_seq_pkg::PAIR_CODE_W];
		return c[adc_seq_pkg::PAIR_EN_BIT] && (c[1:0] != adc_seq_pkg::MUX_INVALID);
	endfunction

	// Next usable pair after cur, wrapping; MSB flags success
	function automatic logic [2:0] next_pair(input logic [11:0] cfg, input logic [1:0] cur);
		logic [2:0] r;
		logic [1:0] p;
		r = '0;
		for (int k = NUM_PAIRS; k >= 1; k--) begin
			p = 2'((int'(cur) + k) % NUM_PAIRS);
			if (pair_ok(cfg, p)) begin
				r = {1'b1, p};
			end
		end
		return r;
	endfunction

	// narrow variant scans pair 0 only
	assign first_pair = next_pair(q.cfg, 2'(NUM_PAIRS - 1));
	assign after_pair = next_pair(q.cfg, q.pair);

	always_comb begin
		d = q;
		d.sync1 = pins;
		d.sync2 = q.sync1;
		d.sync3 = q.sync2;
		push = 1'b0;
		pop = 1'b0;
		push_word.result = (q.code == adc_seq_pkg::MUX_DIFF && sample_diff_neg) ? '0 : sample_value;
		push_word.info = {q.pair, q.code};
		case (q.state)
			ST_IDLE: begin
				if (cs_fall) begin
					d.state = ST_SHIFT_IN;
					d.bit_cnt = '0;
				end
			end
			ST_SHIFT_IN: begin
				if (cs_rise) begin
					d.state = ST_IDLE;
				end else if (sclk_rise) begin
					d.in_sh = {q.in_sh[14:0], sdi};
					d.bit_cnt = q.bit_cnt + 5'h01;
					if (q.bit_cnt == 5'(adc_seq_pkg::MODE_BITS - 1)) begin
						if (mode_now == adc_seq_pkg::MODE_SINGLE) begin
							d.mode_auto = 1'b0;
						end else if (mode_now == adc_seq_pkg::MODE_AUTO) begin
							d.mode_auto = 1'b1;
						end else begin
							d.state = ST_HOLD;
							d.mode_auto = 1'b0;
							d.info = {2'h0, adc_seq_pkg::MUX_INVALID};
						end
					end else if (!q.mode_auto && q.bit_cnt == 5'(adc_seq_pkg::SINGLE_BITS - 1)) begin
						d.info = {q.in_sh[2:0], sdi};
						d.state = ST_HOLD;
					end else if (q.mode_auto && q.bit_cnt == 5'(adc_seq_pkg::AUTO_BITS - 1)) begin
						d.cfg = {q.in_sh[10:0], sdi};
						d.state = ST_HOLD;
					end
				end
			end
			ST_HOLD: begin
				if (cs_rise) begin
					d.osc_cnt = '0;
					if (q.mode_auto) begin
						d.pair = first_pair[1:0];
						d.code = q.cfg[int'(first_pair[1:0])*adc_seq_pkg::PAIR_CODE_W +: 2];
						d.state = first_pair[2] ? ST_START : ST_IDLE;
					end else begin
						d.pair = WIDE_VARIANT ? q.info[3:2] : 2'h0;
						d.code = q.info[1:0];
						d.state = (q.info[1:0] == adc_seq_pkg::MUX_INVALID) ? ST_IDLE : ST_START;
					end
				end
			end
			ST_START: begin
				if (cs_fall) begin
					d.state = ST_SHIFT_IN;
					d.bit_cnt = '0;
				// start one to two periods later
				end else if (osc_rise) begin
					if (q.osc_cnt + 5'h01 >= adc_seq_pkg::START_OSC_EDGES) begin
						// Full FIFO holds the start back
						if (fifo_in_ready) begin
							d.osc_cnt = '0;
							d.eoc = 1'b0;
							d.state = ST_CONV;
						end
					end else begin
						d.osc_cnt = q.osc_cnt + 5'h01;
					end
				end
			end
			ST_CONV: begin
				if (cs_fall) begin
					d.eoc = 1'b1;
					d.state = ST_SHIFT_IN;
					d.bit_cnt = '0;
				end else if (osc_rise) begin
					d.osc_cnt = q.osc_cnt + 5'h01;
					if (q.osc_cnt + 5'h01 == adc_seq_pkg::CONV_OSC_PERIODS) begin
						push = 1'b1;
						d.eoc = 1'b1;
						d.state = ST_READY;
					end
				end
			end
			ST_READY: begin
				// Result held until select falls
				if (cs_fall && fifo_out_valid) begin
					pop = 1'b1;
					// result LSB first, info MSB first
					d.out_sh = {pop_word.info[0], pop_word.info[1], pop_word.info[2],
						pop_word.info[3], pop_word.result};
					d.bit_cnt = '0;
					d.state = ST_SHIFT_OUT;
				end
			end
			ST_SHIFT_OUT, ST_HIZ: begin
				if (cs_rise) begin
					d.sdo_oe = 1'b0;
					d.osc_cnt = '0;
					d.state = ST_START;
					if (q.mode_auto) begin
						d.pair = after_pair[1:0];
						d.code = q.cfg[int'(after_pair[1:0])*adc_seq_pkg::PAIR_CODE_W +: 2];
					end
					// single mode reuses the same input
				end else if (sclk_rise && q.state == ST_SHIFT_OUT) begin
					if (q.bit_cnt < 5'(adc_seq_pkg::OUT_BITS)) begin
						d.sdo = q.out_sh[0];
						d.sdo_oe = 1'b1;
						d.out_sh = {1'b0, q.out_sh[11:1]};
						d.bit_cnt = q.bit_cnt + 5'h01;
					end else begin
						d.sdo_oe = 1'b0;
						d.state = ST_HIZ;
					end
				end
			end
			default: begin
				d.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.sync1.cs_n <= 1'b1;
			q.sync2.cs_n <= 1'b1;
			q.sync3.cs_n <= 1'b1;
			q.eoc <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Result buffer
	// ****************************************
	word_fifo #(
		.WIDTH($bits(adc_seq_pkg::out_word_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(push_word),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(pop_word)
	);

	assign serial_out = q.sdo;
	assign serial_out_oe = q.sdo_oe;
	assign eoc = q.eoc;
	assign mux_pair = q.pair;
	assign mux_code = q.code;
	assign auto_mode = q.mode_auto;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	logic [4:0] osc_seen;
	logic [9:0] low_cyc;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			osc_seen <= '0;
			low_cyc <= '0;
		end else begin
			osc_seen <= (q.state == ST_CONV) ? osc_seen + 5'(osc_rise) : 5'h00;
			low_cyc <= q.eoc ? 10'h000 : low_cyc + 10'h001;
		end
	end

	property p_single_addr;
		q.state == ST_SHIFT_IN && sclk_rise && !cs_rise && q.bit_cnt == 5'h03 && mode_now == 4'hA
			|=> !q.mode_auto && q.state == ST_SHIFT_IN;
	endproperty
	a_single_addr: assert property (p_single_addr) else $error("single address not taken");

	property p_conv_len;
		q.state == ST_CONV && d.state == ST_READY |-> osc_seen == 5'h10 && osc_rise;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

	property p_eoc_fall;
		$fell(q.eoc) |-> $past(q.state) == ST_START && $past(osc_rise);
	endproperty
	a_eoc_fall: assert property (p_eoc_fall) else $error("end flag fell outside start");

	property p_abort;
		q.state == ST_CONV && cs_fall |=> q.eoc && q.state == ST_SHIFT_IN && q.bit_cnt == 5'h00;
	endproperty
	a_abort: assert property (p_abort) else $error("conversion not aborted");

	property p_zero_neg;
		push && q.code == 2'h1 && sample_diff_neg |-> ##1 q.state == ST_READY ##0 q.eoc
			##0 fifo_out_valid && pop_word.result == 8'h00;
	endproperty
	a_zero_neg: assert property (p_zero_neg) else $error("negative difference not zero");

	property p_first_bit;
		q.state == ST_SHIFT_OUT && sclk_rise && !cs_rise && q.bit_cnt == 5'h00
			|=> serial_out_oe && serial_out == $past(q.out_sh[0]);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("first output bit wrong");

	property p_hiz;
		q.state == ST_HIZ |-> !serial_out_oe;
	endproperty
	a_hiz: assert property (p_hiz) else $error("output driven after word");

	property p_invalid;
		q.state == ST_HOLD && cs_rise && !q.mode_auto && q.info[1:0] == 2'h3
			|=> q.state == ST_IDLE ##1 q.eoc [*4];
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid code started work");

	property p_hold_stable;
		q.state == ST_HOLD && !cs_rise |=> $stable(q.info) && $stable(q.cfg);
	endproperty
	a_hold_stable: assert property (p_hold_stable) else $error("held fields changed");

	property p_eoc_bound;
		low_cyc <= 10'(adc_seq_pkg::CONV_MAX_CYC);
	endproperty
	a_eoc_bound: assert property (p_eoc_bound) else $error("conversion too long");

	c_single_read: cover property (q.state == ST_READY && cs_fall ##[1:400] q.state == ST_HIZ);
	c_auto_next: cover property (q.mode_auto && q.state == ST_HIZ && cs_rise ##1 q.state == ST_START);
	c_abort: cover property (q.state == ST_CONV && cs_fall);
endmodule

// ==== dv/host_model.sv ====
// Host side model driving the serial link of the sequencer
`timescale 1ns/1ns

module host_model (
	// Clock
	input wire logic clk_sys,
	// Serial link
	output logic cs_n,
	output logic sclk,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	// Half of the 800 ns link clock period
	localparam int HALF = 4;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		serial_in = 1'b0;
	end

	task automatic ticks(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic send(input logic [15:0] w, input int n);
		ticks(1);
		cs_n = 1'b0;
		ticks(HALF);
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = w[i];
			ticks(HALF);
			sclk = 1'b1;
			ticks(HALF);
			sclk = 1'b0;
		end
		// Released line must not keep the last bit
		serial_in = ~serial_in;
		ticks(HALF);
		cs_n = 1'b1;
	endtask

	// Thirteenth rise checks release; raising select restarts
	task automatic read(output logic [11:0] w, output logic oe_all, output logic oe_end);
		oe_all = 1'b1;
		ticks(1);
		cs_n = 1'b0;
		ticks(HALF);
		for (int i = 0; i < 13; i++) begin
			sclk = 1'b1;
			serial_in = ~serial_in;
			ticks(HALF);
			if (i < 12) begin
				w[11 - i] = serial_out;
				oe_all = oe_all & serial_out_oe;
			end
			sclk = 1'b0;
			ticks(HALF);
		end
		oe_end = serial_out_oe;
		cs_n = 1'b1;
	endtask
endmodule

// ==== dv/adc_conversion_mode_sequencer_tb.sv ====
// Self-checking bench for the conversion mode sequencer
`timescale 1ns/1ns

module adc_conversion_mode_sequencer_tb;
	// Oscillator period in system clocks, 1 MHz
	localparam int OSC_CYC = 10;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic osc = 1'b0;
	logic cs_n, sclk, serial_in, serial_out, serial_out_oe, eoc, auto_mode;
	logic sample_diff_neg = 1'b0;
	logic [7:0] sample_value = 8'h00;
	logic [1:0] mux_pair, mux_code;
	int err_count = 0;
	int samples_checked = 0;

	always #50 clk_sys = ~clk_sys;

	always begin
		repeat (OSC_CYC / 2) @(negedge clk_sys);
		osc = ~osc;
	end

	adc_conversion_mode_sequencer uut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.sclk(sclk),
		.serial_in(serial_in),
		.serial_out(serial_out),
		.serial_out_oe(serial_out_oe),
		.conversion_oscillator(osc),
		.eoc(eoc),
		.sample_value(sample_value),
		.sample_diff_neg(sample_diff_neg),
		.mux_pair(mux_pair),
		.mux_code(mux_code),
		.auto_mode(auto_mode)
	);

	host_model host (
		.clk_sys(clk_sys),
		.cs_n(cs_n),
		.sclk(sclk),
		.serial_in(serial_in),
		.serial_out(serial_out),
		.serial_out_oe(serial_out_oe)
	);

	// ****************************************
	// Shared helpers
	// ****************************************
	task automatic complete_run();
		if (err_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic wait_eoc(input logic lvl, input int lim, output int n);
		n = 0;
		while (eoc !== lvl) begin
			@(negedge clk_sys);
			n++;
			if (n > lim) begin
				check(1'b0, "end flag wait ran out");
				complete_run();
			end
		end
	endtask

	// Start within two periods, done after 17 to 18
	task automatic conv();
		int n;
		wait_eoc(1'b0, 2 * OSC_CYC + 6, n);
		wait_eoc(1'b1, 18 * OSC_CYC, n);
		check(n >= 17 * OSC_CYC - 2, "conversion too short");
	endtask

	task automatic rd(input logic [7:0] res, input logic [3:0] info);
		logic [11:0] w;
		logic [7:0] rev;
		logic a, e;
		rev = {<<{res}};
		host.read(w, a, e);
		check(w === {rev, info}, "output word");
		check(a, "output enable dropped in word");
		check(e === 1'b0, "output not released");
	endtask

	task automatic stay_idle();
		repeat (4 * OSC_CYC) begin
			@(negedge clk_sys);
			check(eoc === 1'b1, "conversion started");
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		check(eoc === 1'b1 && serial_out_oe === 1'b0, "reset outputs");
		check(auto_mode === 1'b0 && mux_pair === 2'h0 && mux_code === 2'h0, "reset mux");
	endtask

	task automatic t_single();
		sample_value = 8'hA5;
		host.send(16'h0297, 10);
		conv();
		check(mux_pair === 2'h1 && mux_code === adc_seq_pkg::MUX_DIFF, "single mux");
		rd(8'hA5, 4'h5);
		sample_diff_neg = 1'b1;
		conv();
		rd(8'h00, 4'h5);
		sample_diff_neg = 1'b0;
	endtask

	task automatic t_abort();
		int n;
		wait_eoc(1'b0, 2 * OSC_CYC + 6, n);
		host.send(16'h00A3, 8);
		check(eoc === 1'b1, "conversion not aborted");
		stay_idle();
	endtask

	task automatic t_auto();
		sample_value = 8'h3C;
		host.send(16'hE034, 16);
		conv();
		check(auto_mode === 1'b1 && mux_pair === 2'h0, "auto first pair");
		check(mux_code === adc_seq_pkg::MUX_EVEN, "auto first code");
		rd(8'h3C, 4'h0);
		conv();
		check(mux_pair === 2'h1 && mux_code === adc_seq_pkg::MUX_ODD, "auto next pair");
		rd(8'h3C, 4'h6);
		conv();
		rd(8'h3C, 4'h0);
	endtask

	task automatic t_mode_change();
		int n;
		wait_eoc(1'b0, 2 * OSC_CYC + 6, n);
		host.send(16'h00C5, 8);
		stay_idle();
		sample_value = 8'h81;
		host.send(16'h00A8, 8);
		conv();
		check(auto_mode === 1'b0 && mux_pair === 2'h2, "back to single");
		check(mux_code === adc_seq_pkg::MUX_EVEN, "single even code");
		rd(8'h81, 4'h8);
	endtask

	initial begin
		repeat (20) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		t_reset();
		t_single();
		t_abort();
		t_auto();
		t_mode_change();
		complete_run();
	end
endmodule
